// ---- hw/cslp_ctrl.sv ----
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Both straps high: normal, programmable synthesizer
// - Mode strap low: one-to-one oscillator clocking
// - Supply strap low: synthesizer bypassed, half rate
// - Output divider further divides in those modes
// - Both straps low: factory test, synthesizer bypassed
// - Power-mode field selects one of four modes
// - Block bus, finish cycle, then stop clocks
// - Power mode resets normal, exit returns normal
// - Single-chip mode stops only output clock
// - Sleep stops every clock and oscillator
// - Reset, unmasked pins, timers (except in sleep) end modes
// - Mask bit gates interrupt pin wake-up
// - Bit four selects time-base clock source
// - Bit five gates decrementer clock, resets one
// - Bit six enables reset on lock loss
// - Bit seven enables reset on oscillator loss
// - Field codes: normal, single, doze, sleep
module cslp_ctrl
  import cslp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        synth_supply_strap,
  input  wire logic        clock_source_strap,
  input  wire logic        bus_cycle_busy,
  input  wire logic [1:0]  wake_irq,
  input  wire logic        reset_output_evt,
  input  wire logic        dec_irq,
  input  wire logic        pit_irq,
  input  wire logic        lock_loss,
  input  wire logic        osc_loss,
  output logic             clkout_en,
  output logic             core_clk_en,
  output logic             osc_run,
  output logic             synth_run,
  output logic             synth_programmable,
  output logic             bus_hold,
  output logic [1:0]       power_mode,
  output logic [1:0]       clock_source,
  output logic [3:0]       multiplier_field,
  output logic             timebase_tick,
  output logic             dec_tick,
  output logic             lock_reset_req,
  output logic             osc_reset_req
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0]    scc_r,   scc_nxt;
  cslp_src_t      src_r,   src_nxt;
  cslp_lp_state_t st_r,    st_nxt;
  logic [31:0]    rdata_r, rdata_nxt;
  logic           lrq_r,   lrq_nxt;
  logic           orq_r,   orq_nxt;
  logic           exit_evt;
  logic           wake_pin;
  logic [1:0]     pmode;
  logic           halted;
  logic [31:0]    status;

  cslp_clk_if ck ();

  assign pmode  = scc_r[CSLP_PMODE_LSB +: 2];
  assign halted = (st_r == CSLP_HALT);

  // ****************************************
  // Register bus and low-power sequencing
  // ****************************************
  always_comb begin
    wake_pin = (|wake_irq) && scc_r[CSLP_WAKE_MASK_BIT];
    // Timer interrupts cannot end sleep since their clocks are stopped
    exit_evt = reset_output_evt || wake_pin || ((dec_irq || pit_irq) && (pmode != CSLP_PM_SLEEP));
    src_nxt  = src_r;
    scc_nxt  = scc_r;
    st_nxt   = st_r;
    if (reg_wr && (reg_addr == CSLP_SCC_ADDR)) begin
      scc_nxt = (reg_wdata & CSLP_SCC_WMASK) | (scc_r & ~CSLP_SCC_WMASK);
    end
    case (st_r)
      CSLP_RUN: begin
        if (scc_nxt[CSLP_PMODE_LSB +: 2] != CSLP_PM_NORMAL) begin
          st_nxt = CSLP_DRAIN;
        end
      end
      CSLP_DRAIN: begin
        if (exit_evt) begin
          st_nxt = CSLP_RUN;
        end else if (!bus_cycle_busy) begin
          st_nxt = CSLP_HALT;
        end
      end
      CSLP_HALT: begin
        if (exit_evt) begin
          st_nxt = CSLP_RUN;
        end
      end
      default: begin
        st_nxt = CSLP_RUN;
      end
    endcase
    // Exit wins over a concurrent write so a wake-up is never lost
    if ((st_r != CSLP_RUN) && exit_evt) begin
      scc_nxt[CSLP_PMODE_LSB +: 2] = CSLP_PM_NORMAL;
    end
    lrq_nxt = lock_loss && scc_r[CSLP_LOCK_RST_BIT] && synth_run;
    orq_nxt = osc_loss && scc_r[CSLP_OSC_RST_BIT];
  end

  always_comb begin
    status                                = '0;
    status[CSLP_ST_SRC_LSB +: 2]          = src_r;
    status[CSLP_ST_STATE_LSB +: 2]        = st_r;
    status[CSLP_ST_HOLD_BIT]              = bus_hold;
    rdata_nxt                             = '0;
    if (reg_rd) begin
      if (reg_addr == CSLP_SCC_ADDR) begin
        rdata_nxt = scc_r & CSLP_SCC_WMASK;
      end else if (reg_addr == CSLP_STAT_ADDR) begin
        rdata_nxt = status;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      // Straps are caught while the synchronous reset is held
      src_r   <= cslp_src_t'({synth_supply_strap, clock_source_strap});
      scc_r   <= CSLP_SCC_RESET;
      st_r    <= CSLP_RUN;
      rdata_r <= '0;
      lrq_r   <= 1'b0;
      orq_r   <= 1'b0;
    end else begin
      src_r   <= src_nxt;
      scc_r   <= scc_nxt;
      st_r    <= st_nxt;
      rdata_r <= rdata_nxt;
      lrq_r   <= lrq_nxt;
      orq_r   <= orq_nxt;
    end
  end

  // ****************************************
  // Clock gating
  // ****************************************
  assign ck.run_osc   = !(halted && (pmode == CSLP_PM_SLEEP));
  assign ck.half_rate = (src_r == CSLP_SRC_BYPASS);
  // Test mode skips the divider chain
  assign ck.odiv      = (src_r == CSLP_SRC_TEST) ? 4'h0 : scc_r[CSLP_ODIV_LSB +: 4];

  cslp_clkgen u_clkgen (
    .mclk  (mclk),
    .reset (reset),
    .ck    (ck)
  );

  always_comb begin
    osc_run            = ck.run_osc;
    synth_run          = ck.run_osc && src_r[1];
    synth_programmable = (src_r == CSLP_SRC_NORMAL);
    bus_hold           = (st_r != CSLP_RUN);
    clkout_en          = ck.sys_tick && !halted;
    core_clk_en        = ck.sys_tick && !(halted && (pmode != CSLP_PM_SINGLE));
    timebase_tick      = scc_r[CSLP_TB_SRC_BIT] ? (ck.sys_q_tick && core_clk_en) : ck.osc_q_tick;
    dec_tick           = timebase_tick && scc_r[CSLP_DEC_GATE_BIT];
    power_mode         = pmode;
    clock_source       = src_r;
    multiplier_field   = scc_r[CSLP_MULT_LSB +: 4];
    reg_rdata          = rdata_r;
    lock_reset_req     = lrq_r;
    osc_reset_req      = orq_r;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ****************************************
  // Clock source
  // ****************************************
  AST_NORMAL_PROG: assert property (src_r == CSLP_SRC_NORMAL |-> synth_programmable && synth_run == osc_run)
    else $error("Normal source without programmable synthesizer");

  // Straps are only caught in reset, so the source never moves while running
  AST_SRC_HELD: assert property ($stable(clock_source))
    else $error("Clock source changed outside reset");

  AST_ONE2ONE: assert property (src_r == CSLP_SRC_ONE2ONE |-> !synth_programmable && synth_run == osc_run)
    else $error("One-to-one source misconfigured");

  AST_BYPASS_HALF: assert property ((src_r == CSLP_SRC_BYPASS) && ck.sys_tick |=> !ck.sys_tick && !synth_run)
    else $error("Bypass clock exceeds half rate");

  // A write may lower the divider at the very tick, which legally allows a tick next cycle
  AST_ODIV_DIV: assert property ((ck.odiv != 4'h0) && ck.sys_tick && !(reg_wr && (reg_addr == CSLP_SCC_ADDR))
    |=> !ck.sys_tick)
    else $error("Divider field ignored");

  AST_TEST_SRC: assert property (src_r == CSLP_SRC_TEST |-> !synth_run && !synth_programmable)
    else $error("Synthesizer used in test mode");

  // ****************************************
  // Power sequencing
  // ****************************************
  AST_DRAIN_WAIT: assert property ((st_r == CSLP_DRAIN) && bus_cycle_busy && !exit_evt |=> st_r == CSLP_DRAIN && bus_hold)
    else $error("Clocks stopped during a bus cycle");

  AST_ENTER_LP: assert property ((st_r == CSLP_RUN) && reg_wr && (reg_addr == CSLP_SCC_ADDR)
    && (reg_wdata[CSLP_PMODE_LSB +: 2] != CSLP_PM_NORMAL) |=> bus_hold && (pmode != CSLP_PM_NORMAL))
    else $error("Low-power select did not hold the bus");

  AST_NORMAL_IDLE: assert property (st_r == CSLP_RUN |-> !bus_hold && (clkout_en == ck.sys_tick))
    else $error("Normal mode gated a clock or held the bus");

  AST_EXIT_NORMAL: assert property ((st_r != CSLP_RUN) && exit_evt |=> (pmode == CSLP_PM_NORMAL) && (st_r == CSLP_RUN))
    else $error("Exit event did not restore normal mode");

  AST_SINGLE_CHIP: assert property (halted && (pmode == CSLP_PM_SINGLE) |-> !clkout_en && core_clk_en == ck.sys_tick)
    else $error("Single-chip gating wrong");

  AST_DOZE: assert property (halted && (pmode == CSLP_PM_DOZE) |-> !clkout_en && !core_clk_en && osc_run)
    else $error("Doze gating wrong");

  AST_OSC_KEPT: assert property (halted && (pmode != CSLP_PM_SLEEP) |-> osc_run)
    else $error("Oscillator stopped outside sleep");

  AST_SLEEP: assert property (halted && (pmode == CSLP_PM_SLEEP) |-> !osc_run && !synth_run && !timebase_tick)
    else $error("Sleep left a clock running");

  AST_SLEEP_TIMER: assert property (halted && (pmode == CSLP_PM_SLEEP) && dec_irq && !reset_output_evt && !(|wake_irq)
    |=> halted)
    else $error("Timer ended sleep mode");

  AST_RESET_OUT_WAKE: assert property ((st_r != CSLP_RUN) && reset_output_evt |=> st_r == CSLP_RUN)
    else $error("Reset output did not end low-power mode");

  AST_MASK_PIN: assert property (halted && !scc_r[CSLP_WAKE_MASK_BIT] && (|wake_irq) && !reset_output_evt && !dec_irq
    && !pit_irq |=> halted)
    else $error("Masked pin woke the device");

  AST_PIN_WAKE: assert property (halted && scc_r[CSLP_WAKE_MASK_BIT] && (|wake_irq) |=> st_r == CSLP_RUN)
    else $error("Unmasked pin did not wake the device");

  // ****************************************
  // Control bits
  // ****************************************
  AST_DEC_GATE: assert property (dec_tick |-> timebase_tick && scc_r[CSLP_DEC_GATE_BIT])
    else $error("Decrementer tick while gated");

  AST_DEC_OFF: assert property (!scc_r[CSLP_DEC_GATE_BIT] |-> !dec_tick)
    else $error("Decrementer clock not gated off");

  AST_TB_OSC: assert property (!scc_r[CSLP_TB_SRC_BIT] && ck.osc_q_tick |-> timebase_tick)
    else $error("Time base not from oscillator");

  AST_LOSS_RST: assert property (osc_loss && scc_r[CSLP_OSC_RST_BIT] |=> osc_reset_req)
    else $error("Oscillator loss reset missed");

  AST_LOCK_RST: assert property (!scc_r[CSLP_LOCK_RST_BIT] |=> !lock_reset_req)
    else $error("Lock loss reset while disabled");

  AST_LOCK_SET: assert property (lock_loss && scc_r[CSLP_LOCK_RST_BIT] && synth_run |=> lock_reset_req)
    else $error("Lock loss reset missed");

  // ****************************************
  // Register bus
  // ****************************************
  AST_RSVD_ZERO: assert property (reg_rd && (reg_addr == CSLP_SCC_ADDR) |=> (reg_rdata & ~CSLP_SCC_WMASK) == 32'h0)
    else $error("Reserved bits read non-zero");

  AST_RSVD_WRITE: assert property (reg_wr && (reg_addr == CSLP_SCC_ADDR) |=> (scc_r & ~CSLP_SCC_WMASK) == 32'h0)
    else $error("Write reached a reserved bit");

  AST_WRITE_LAND: assert property ((st_r == CSLP_RUN) && reg_wr && (reg_addr == CSLP_SCC_ADDR)
    |=> (scc_r & CSLP_SCC_WMASK) == ($past(reg_wdata) & CSLP_SCC_WMASK))
    else $error("Control write did not land");

  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data outside a read");

  AST_UNMAPPED_ZERO: assert property (reg_rd && (reg_addr != CSLP_SCC_ADDR) && (reg_addr != CSLP_STAT_ADDR)
    |=> reg_rdata == 32'h0)
    else $error("Unmapped read returned data");

  // ****************************************
  // Coverage of the main scenarios
  // ****************************************
  COV_SLEEP_WAKE: cover property (halted && (pmode == CSLP_PM_SLEEP) ##1 st_r == CSLP_RUN);
  COV_DOZE_TIMER: cover property (halted && (pmode == CSLP_PM_DOZE) && pit_irq ##1 st_r == CSLP_RUN);
  COV_DRAIN_BUSY: cover property ((st_r == CSLP_DRAIN) && bus_cycle_busy ##1 st_r == CSLP_HALT);
  COV_SINGLE_DEC: cover property (halted && (pmode == CSLP_PM_SINGLE) && dec_irq ##1 st_r == CSLP_RUN);
  COV_PIN_WAKE: cover property (halted && scc_r[CSLP_WAKE_MASK_BIT] && (|wake_irq) ##1 st_r == CSLP_RUN);

endmodule // cslp_ctrl

// ---- inc/cslp_pkg.sv ----
package cslp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] CSLP_SCC_ADDR   = 32'h8007fc50;
  localparam logic [31:0] CSLP_STAT_ADDR  = 32'h8007fc58;
  localparam logic [31:0] CSLP_SCC_RESET  = 32'h04100003;
  localparam logic [31:0] CSLP_SCC_WMASK  = 32'h1f78030f;

  // Field positions, little-endian bit numbers of the 32-bit word
  localparam int CSLP_WAKE_MASK_BIT = 28;
  localparam int CSLP_TB_SRC_BIT    = 27;
  localparam int CSLP_DEC_GATE_BIT  = 26;
  localparam int CSLP_LOCK_RST_BIT  = 25;
  localparam int CSLP_OSC_RST_BIT   = 24;
  localparam int CSLP_MULT_LSB      = 19;
  localparam int CSLP_PMODE_LSB     = 8;
  localparam int CSLP_ODIV_LSB      = 0;

  // Status register fields
  localparam int CSLP_ST_SRC_LSB  = 0;
  localparam int CSLP_ST_STATE_LSB = 4;
  localparam int CSLP_ST_HOLD_BIT = 6;

  // ****************************************
  // Modes and encodings
  // ****************************************
  localparam logic [1:0] CSLP_PM_NORMAL  = 2'h0;
  localparam logic [1:0] CSLP_PM_SINGLE  = 2'h1;
  localparam logic [1:0] CSLP_PM_DOZE    = 2'h2;
  localparam logic [1:0] CSLP_PM_SLEEP   = 2'h3;

  localparam int         CSLP_PRE_W      = 10;
  localparam logic [3:0] CSLP_ODIV_MAX   = 4'ha;
  localparam logic [1:0] CSLP_QUART_LAST = 2'h3;

  // Clock source, coded {synth_supply_strap, clock_source_strap}
  typedef enum logic [1:0] {
    CSLP_SRC_TEST    = 2'h0,
    CSLP_SRC_BYPASS  = 2'h1,
    CSLP_SRC_ONE2ONE = 2'h2,
    CSLP_SRC_NORMAL  = 2'h3
  } cslp_src_t;

  typedef enum logic [1:0] {
    CSLP_RUN   = 2'h0,
    CSLP_DRAIN = 2'h1,
    CSLP_HALT  = 2'h3
  } cslp_lp_state_t;

  // Prescaler mask: divide by 2**odiv, saturating at 1024
  function automatic logic [CSLP_PRE_W-1:0] cslp_odiv_mask(input logic [3:0] odiv);
    logic [CSLP_PRE_W:0] one;
    one = {{CSLP_PRE_W{1'b0}}, 1'b1} << ((odiv > CSLP_ODIV_MAX) ? CSLP_ODIV_MAX : odiv);
    return CSLP_PRE_W'(one - 1'b1);
  endfunction

endpackage

// ---- inc/cslp_clk_if.sv ----
`timescale 1ns/1ps
interface cslp_clk_if;
  import cslp_pkg::*;
  logic       run_osc;
  logic       half_rate;
  logic [3:0] odiv;
  logic       sys_tick;
  logic       osc_q_tick;
  logic       sys_q_tick;

  modport gen (input run_osc, input half_rate, input odiv,
               output sys_tick, output osc_q_tick, output sys_q_tick);
  modport ctl (output run_osc, output half_rate, output odiv,
               input sys_tick, input osc_q_tick, input sys_q_tick);
endinterface

// ---- hw/cslp_clkgen.sv ----
`timescale 1ns/1ps
module cslp_clkgen
  import cslp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  cslp_clk_if.gen   ck
);

  logic                  half_r,  half_nxt;
  logic [CSLP_PRE_W-1:0] pre_r,   pre_nxt;
  logic [1:0]            oq_r,    oq_nxt;
  logic [1:0]            sq_r,    sq_nxt;
  logic                  base;
  logic [CSLP_PRE_W-1:0] mask;

  // ****************************************
  // Tick generation
  // ****************************************
  always_comb begin
    mask          = cslp_odiv_mask(ck.odiv);
    base          = ck.run_osc && (!ck.half_rate || half_r);
    ck.sys_tick   = base && ((pre_r & mask) == mask);
    ck.osc_q_tick = ck.run_osc && (oq_r == CSLP_QUART_LAST);
    ck.sys_q_tick = ck.sys_tick && (sq_r == CSLP_QUART_LAST);
    half_nxt      = ck.run_osc ? !half_r : half_r;
    pre_nxt       = base ? pre_r + 1'b1 : pre_r;
    oq_nxt        = ck.run_osc ? oq_r + 1'b1 : oq_r;
    sq_nxt        = ck.sys_tick ? sq_r + 1'b1 : sq_r;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      half_r <= 1'b0;
      pre_r  <= '0;
      oq_r   <= 2'h0;
      sq_r   <= 2'h0;
    end else begin
      half_r <= half_nxt;
      pre_r  <= pre_nxt;
      oq_r   <= oq_nxt;
      sq_r   <= sq_nxt;
    end
  end

endmodule // cslp_clkgen

// ---- dv/cslp_far_model.sv ----
`timescale 1ns/1ps
module cslp_far_model (
  input  wire logic       mclk,
  input  wire logic       start,
  input  wire logic [3:0] busy_len,
  input  wire logic       fire,
  input  wire logic [2:0] evt_sel,
  output logic            bus_cycle_busy,
  output logic [1:0]      wake_irq,
  output logic            reset_output_evt,
  output logic            dec_irq,
  output logic            pit_irq
);
  // ****************************************
  // Bus cycle in flight and wake-up sources
  // ****************************************
  // Event codes: 0 reset output, 1 wake pin, 2 decrementer, 3 periodic tick
  logic [3:0] busy_r = 4'h0;
  logic [1:0] hold_r = 2'h0;
  logic [2:0] sel_r  = 3'h0;
  logic       on;

  always_ff @(posedge mclk) begin
    if (start) begin
      busy_r <= busy_len;
    end else if (busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
    if (fire) begin
      hold_r <= 2'h3;
      sel_r  <= evt_sel;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  assign on               = (hold_r != 2'h0);
  assign bus_cycle_busy   = (busy_r != 4'h0);
  assign reset_output_evt = on && (sel_r == 3'h0);
  assign wake_irq         = {on && (sel_r == 3'h1), 1'b0};
  assign dec_irq          = on && (sel_r == 3'h2);
  assign pit_irq          = on && (sel_r == 3'h3);
endmodule // cslp_far_model

// ---- dv/test_clock_source_lowpower_ctrl.sv ----
`timescale 1ns/1ps
module test_clock_source_lowpower_ctrl;
  import cslp_pkg::*;
  logic        mclk, reset, reg_wr, reg_rd, ss, cs, lock_loss, osc_loss, start, fire;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [3:0]  busy_len, multiplier_field;
  logic [2:0]  evt_sel;
  logic [1:0]  wake_irq, power_mode, clock_source;
  logic        busy, rst_evt, dec_irq, pit_irq, clkout_en, core_clk_en, osc_run, synth_run;
  logic        synth_programmable, bus_hold, timebase_tick, dec_tick, lock_reset_req, osc_reset_req;
  int          num_errors, total_checks, i, k, c_clk, c_core, c_tb, c_dec;
  logic [1:0]  pm_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [2:0]  evt_tab [4] = '{3'h2, 3'h3, 3'h1, 3'h0};
  logic        msk_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int          core_tab [4] = '{16, 0, 0, 0};
  int          clk_tab [4] = '{32, 2, 4, 4};

  cslp_ctrl i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synth_supply_strap(ss),
    .clock_source_strap(cs), .bus_cycle_busy(busy), .wake_irq(wake_irq), .reset_output_evt(rst_evt),
    .dec_irq(dec_irq), .pit_irq(pit_irq), .lock_loss(lock_loss), .osc_loss(osc_loss),
    .clkout_en(clkout_en), .core_clk_en(core_clk_en), .osc_run(osc_run), .synth_run(synth_run),
    .synth_programmable(synth_programmable), .bus_hold(bus_hold), .power_mode(power_mode),
    .clock_source(clock_source), .multiplier_field(multiplier_field), .timebase_tick(timebase_tick),
    .dec_tick(dec_tick), .lock_reset_req(lock_reset_req), .osc_reset_req(osc_reset_req));

  cslp_far_model i_far (.mclk(mclk), .start(start), .busy_len(busy_len), .fire(fire), .evt_sel(evt_sel),
    .bus_cycle_busy(busy), .wake_irq(wake_irq), .reset_output_evt(rst_evt), .dec_irq(dec_irq),
    .pit_irq(pit_irq));

  always #20 mclk = ~mclk;

  // ****************************************
  // Access and checking tasks
  // ****************************************
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= CSLP_SCC_ADDR;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic rst(input logic [1:0] src);
    @(posedge mclk);
    reset <= 1'b1;
    ss    <= src[1];
    cs    <= src[0];
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    #1;
  endtask

  // Counts every enable over n cycles; callers settle first where a divider was just changed
  task automatic cnt(input int n);
    c_clk  = 0;
    c_core = 0;
    c_tb   = 0;
    c_dec  = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      c_clk  += (clkout_en === 1'b1);
      c_core += (core_clk_en === 1'b1);
      c_tb   += (timebase_tick === 1'b1);
      c_dec  += (dec_tick === 1'b1);
    end
  endtask

  task automatic fire_evt(input logic [2:0] s);
    @(posedge mclk);
    fire    <= 1'b1;
    evt_sel <= s;
    @(posedge mclk);
    fire    <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    mclk = 1'b0; reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 32'h0; reg_wdata = 32'h0;
    ss = 1'b1; cs = 1'b1; lock_loss = 1'b0; osc_loss = 1'b0; start = 1'b0; fire = 1'b0;
    busy_len = 4'h0; evt_sel = 3'h0; num_errors = 0; total_checks = 0;
    for (i = 0; i < 4; i++) begin
      rst(i[1:0]);
      check(clock_source, i[1:0]);
      check(synth_programmable, (i == 3));
      cnt(32);
      check(c_clk, clk_tab[i]);
    end
    rd_chk(CSLP_SCC_ADDR, 32'h04100003);
    check(power_mode, 2'h0);
    wr(32'hfffffcff);
    rd_chk(CSLP_SCC_ADDR, 32'h1f78000f);
    check(multiplier_field, 4'hf);
    rd_chk(32'h8007fc54, 32'h0);
    // Time base from oscillator quarter, then with the gate off, then from system quarter
    wr(32'h04100002);
    repeat (16) @(posedge mclk);
    cnt(64);
    check(c_tb, 16);
    check(c_dec, 16);
    wr(32'h00100002);
    cnt(64);
    check(c_dec, 0);
    wr(32'h0c100002);
    repeat (16) @(posedge mclk);
    cnt(64);
    check(c_tb, 4);
    // Loss conditions held while each reset enable combination is tried
    @(posedge mclk);
    lock_loss <= 1'b1;
    osc_loss  <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(32'h04100000 | (i << 24));
      repeat (2) @(posedge mclk);
      #1;
      check(lock_reset_req, i[1]);
      check(osc_reset_req, i[0]);
    end
    @(posedge mclk);
    lock_loss <= 1'b0;
    osc_loss  <= 1'b0;
    // Each low-power mode entered while a bus cycle is still running
    for (k = 0; k < 4; k++) begin
      @(posedge mclk);
      start    <= 1'b1;
      busy_len <= 4'h8;
      @(posedge mclk);
      start    <= 1'b0;
      wr(32'h04100000 | (msk_tab[k] << 28) | (pm_tab[k] << 8));
      check(bus_hold, 1'b1);
      check(power_mode, pm_tab[k]);
      cnt(4);
      check(c_core, 4);
      repeat (8) @(posedge mclk);
      cnt(16);
      check(c_clk, 0);
      check(c_core, core_tab[k]);
      check(osc_run, (pm_tab[k] != 2'h3));
      check(synth_run, (pm_tab[k] != 2'h3));
      if (pm_tab[k] == 2'h3) begin
        fire_evt(3'h3);
        check(power_mode, 2'h3);
        if (msk_tab[k] == 1'b0) begin
          fire_evt(3'h1);
          check(power_mode, 2'h3);
        end
      end
      fire_evt(evt_tab[k]);
      check(power_mode, 2'h0);
      check(bus_hold, 1'b0);
      cnt(16);
      check(c_clk, 16);
    end
    close_out();
  end

  initial begin
    #2000000;
    num_errors++;
    close_out();
  end
endmodule // test_clock_source_lowpower_ctrl
